// ### core/cslk_top.sv
// Configuration and supervision of the drive's serial slave port.
// Assumes a framer on the same clock that reports characters and message ends.
//
// Notes on behaviour
// - Station address 1 to 247, reset 1; only matching messages are answered.
// - Rate code 0, 1, 2 selects 9600, 19200, 38400 bit/s.
// - 8 data bits; codes 0-2 none/even/odd parity 1 stop, 3-5 two stops; reset 1.
// - Error action 0 none, 1 ramp stop, 2 disable, 3 local, 4 local keep, 5 fault.
// - Address, rate, format, error action writes refused while the motor runs.
// - Read-only settings refuse writes and allow reads.
// - Serial commands act only when the matching source selects serial.
// - No remote keypad while the port is a command or reference source.
// - Terminator on when both switches on, off when both off; mixed invalid.
// - Watchdog error after timeout without valid message; armed by first; zero disables.
// - Link status 0 inactive, 1 active, 2 watchdog error.
`timescale 1ns/1ps
`default_nettype none
module cslk_top #(
   parameter int TENTH_CYCLES = cslk_pkg::TENTH_CYCLES,
   parameter logic [15:0] SRC_SERIAL = 16'h0002
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Setting access
   input wire logic par_req,
   input wire logic par_wr,
   input wire logic [9:0] par_idx,
   input wire logic [15:0] par_wdata,
   output logic par_ack,
   output logic par_refused,
   output logic [15:0] par_rdata,
   // Drive state
   input wire logic motor_running,
   input wire logic remote_mode,
   input wire logic iface_present,
   input wire logic fault_reset,
   // Framer
   input wire logic line_idle,
   input wire logic rx_char_err,
   input wire logic msg_end,
   input wire logic msg_crc_ok,
   input wire logic [7:0] msg_addr,
   output logic msg_for_us,
   // Line setup
   output logic [12:0] baud_div,
   output logic parity_en,
   output logic parity_odd,
   output logic two_stop,
   // Commands
   input wire logic [cslk_pkg::CMD_N-1:0] cmd_strobe,
   output logic [cslk_pkg::CMD_N-1:0] cmd_apply,
   output logic keypad_allow,
   // Terminator switch pins
   input wire logic terminator_switch_a,
   input wire logic terminator_switch_b,
   output logic terminator_on,
   output logic terminator_invalid,
   // Supervision
   output logic [1:0] link_status,
   output logic link_timeout_alarm,
   output logic link_timeout_fault,
   output logic err_ramp_stop,
   output logic err_gen_disable,
   output logic err_to_local,
   output logic err_keep_cmds
);
   import cslk_pkg::*;

   // ==========================================================
   // Decoding shared by logic and checks
   function automatic cslk_class_t class_of(input logic [9:0] idx);
      if (idx == IDX_ADDR || idx == IDX_RATE || idx == IDX_FMT || idx == IDX_ACT || idx == IDX_TMO) begin
         return CL_CFG;
      end else if (idx == IDX_STAT) begin
         return CL_RO;
      end else if (idx >= IDX_SRC0 && idx <= IDX_SRC8) begin
         return CL_SRC;
      end
      return CL_NONE;
   endfunction

   function automatic logic value_ok(input logic [9:0] idx, input logic [15:0] v);
      unique case (idx)
         IDX_ADDR: return v >= ADDR_MIN && v <= ADDR_MAX;
         IDX_RATE: return v <= RATE_MAX;
         IDX_FMT: return v <= FMT_MAX;
         IDX_ACT: return v <= ACT_MAX;
         IDX_TMO: return v <= TMO_MAX;
         default: return 1'b1;
      endcase
   endfunction

   function automatic logic [12:0] div_of(input logic [15:0] r);
      unique case (r[1:0])
         2'h1: return DIV_MID;
         2'h2: return DIV_HI;
         default: return DIV_LO;
      endcase
   endfunction

   // ==========================================================
   // Setting store and access answer
   logic [15:0] addr_ff, nxt_addr_ff, rate_ff, nxt_rate_ff, fmt_ff, nxt_fmt_ff;
   logic [15:0] act_ff, nxt_act_ff, tmo_ff, nxt_tmo_ff;
   logic [15:0] src_ff [SRC_N];
   logic [15:0] nxt_src_ff [SRC_N];
   logic ack_ff, nxt_ack_ff, ref_ff, nxt_ref_ff;
   logic [15:0] rdata_ff, nxt_rdata_ff;
   logic [1:0] stat_ff, nxt_stat_ff;
   cslk_class_t cls;
   logic [3:0] src_i;

   assign cls = class_of(par_idx);
   assign src_i = 4'(par_idx - IDX_SRC0);

   always_comb begin
      nxt_addr_ff = addr_ff;
      nxt_rate_ff = rate_ff;
      nxt_fmt_ff = fmt_ff;
      nxt_act_ff = act_ff;
      nxt_tmo_ff = tmo_ff;
      nxt_src_ff = src_ff;
      nxt_ack_ff = par_req;
      nxt_ref_ff = 1'b0;
      nxt_rdata_ff = '0;
      if (par_req && !par_wr) begin
         nxt_ref_ff = (cls == CL_NONE);
         unique case (cls)
            CL_CFG: begin
               unique case (par_idx)
                  IDX_ADDR: nxt_rdata_ff = addr_ff;
                  IDX_RATE: nxt_rdata_ff = rate_ff;
                  IDX_FMT: nxt_rdata_ff = fmt_ff;
                  IDX_ACT: nxt_rdata_ff = act_ff;
                  default: nxt_rdata_ff = tmo_ff;
               endcase
            end
            CL_RO: nxt_rdata_ff = {14'h0000, stat_ff};
            CL_SRC: nxt_rdata_ff = src_ff[src_i];
            default: nxt_rdata_ff = '0;
         endcase
      end else if (par_req) begin
         if (cls == CL_NONE || cls == CL_RO) begin
            nxt_ref_ff = 1'b1;
         end else if (cls == CL_CFG && motor_running) begin
            nxt_ref_ff = 1'b1;
         end else if (!value_ok(par_idx, par_wdata)) begin
            nxt_ref_ff = 1'b1;
         end else if (cls == CL_SRC) begin
            nxt_src_ff[src_i] = par_wdata;
         end else begin
            unique case (par_idx)
               IDX_ADDR: nxt_addr_ff = par_wdata;
               IDX_RATE: nxt_rate_ff = par_wdata;
               IDX_FMT: nxt_fmt_ff = par_wdata;
               IDX_ACT: nxt_act_ff = par_wdata;
               default: nxt_tmo_ff = par_wdata;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_ff <= ADDR_RST;
         rate_ff <= RATE_RST;
         fmt_ff <= FMT_RST;
         act_ff <= ACT_RST;
         tmo_ff <= TMO_RST;
         src_ff <= '{default: SRC_RST};
         ack_ff <= 1'b0;
         ref_ff <= 1'b0;
         rdata_ff <= '0;
      end else begin
         addr_ff <= nxt_addr_ff;
         rate_ff <= nxt_rate_ff;
         fmt_ff <= nxt_fmt_ff;
         act_ff <= nxt_act_ff;
         tmo_ff <= nxt_tmo_ff;
         src_ff <= nxt_src_ff;
         ack_ff <= nxt_ack_ff;
         ref_ff <= nxt_ref_ff;
         rdata_ff <= nxt_rdata_ff;
      end
   end

   // ==========================================================
   // Line setup, taken over only between messages
   logic [12:0] div_ff, nxt_div_ff;
   logic pen_ff, nxt_pen_ff, podd_ff, nxt_podd_ff, two_ff, nxt_two_ff;
   logic [15:0] fmt_par;

   assign fmt_par = (fmt_ff >= FMT_TWO_STOP) ? fmt_ff - FMT_TWO_STOP : fmt_ff;

   always_comb begin
      nxt_div_ff = div_ff;
      nxt_pen_ff = pen_ff;
      nxt_podd_ff = podd_ff;
      nxt_two_ff = two_ff;
      // Mid-frame changes would garble the character on the wire
      if (line_idle) begin
         nxt_div_ff = div_of(rate_ff);
         nxt_pen_ff = (fmt_par != 16'h0000);
         nxt_podd_ff = (fmt_par == 16'h0002);
         nxt_two_ff = (fmt_ff >= FMT_TWO_STOP);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_ff <= DIV_LO;
         pen_ff <= 1'b1;
         podd_ff <= 1'b0;
         two_ff <= 1'b0;
      end else begin
         div_ff <= nxt_div_ff;
         pen_ff <= nxt_pen_ff;
         podd_ff <= nxt_podd_ff;
         two_ff <= nxt_two_ff;
      end
   end

   // ==========================================================
   // Message qualification and watchdog
   logic bad_ff, nxt_bad_ff, hit_ff, nxt_hit_ff;
   logic wd_exp;

   always_comb begin
      // A character error in the closing cycle still spoils the message
      nxt_bad_ff = msg_end ? 1'b0 : (bad_ff | rx_char_err);
      nxt_hit_ff = msg_end && msg_crc_ok && !bad_ff && !rx_char_err
                   && ({8'h00, msg_addr} == addr_ff);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bad_ff <= 1'b0;
         hit_ff <= 1'b0;
      end else begin
         bad_ff <= nxt_bad_ff;
         hit_ff <= nxt_hit_ff;
      end
   end

   cslk_watchdog #(.TENTH_CYCLES(TENTH_CYCLES)) u_wd (
      .clk(clk),
      .rst_b(rst_b),
      .msg_good(hit_ff),
      .timeout(tmo_ff),
      .expired(wd_exp)
   );

   // ==========================================================
   // Error action and status
   logic alm_ff, nxt_alm_ff, flt_ff, nxt_flt_ff;
   logic [3:0] errs_ff, nxt_errs_ff;

   always_comb begin
      nxt_alm_ff = wd_exp;
      // Fault stays until reset by the drive; a new fault wins over the reset
      nxt_flt_ff = (wd_exp && act_ff == 16'(ACT_FAULT)) || (flt_ff && !fault_reset);
      nxt_errs_ff = {4{wd_exp}} & {act_ff == 16'(ACT_LOCAL_KEEP), act_ff == 16'(ACT_LOCAL),
                                   act_ff == 16'(ACT_GEN_DISABLE), act_ff == 16'(ACT_RAMP_STOP)};
      if (!iface_present) begin
         nxt_stat_ff = ST_INACTIVE;
      end else if (wd_exp) begin
         nxt_stat_ff = ST_WDOG_ERR;
      end else begin
         nxt_stat_ff = ST_ACTIVE;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alm_ff <= 1'b0;
         flt_ff <= 1'b0;
         errs_ff <= '0;
         stat_ff <= ST_INACTIVE;
      end else begin
         alm_ff <= nxt_alm_ff;
         flt_ff <= nxt_flt_ff;
         errs_ff <= nxt_errs_ff;
         stat_ff <= nxt_stat_ff;
      end
   end

   // ==========================================================
   // Command source gating and keypad
   logic [CMD_N-1:0] gate, app_ff, nxt_app_ff;
   logic any_serial, kp_ff, nxt_kp_ff;

   always_comb begin
      gate[CMD_LR] = src_ff[0] == SRC_SERIAL;
      gate[CMD_REF] = src_ff[remote_mode ? 2 : 1] == SRC_SERIAL;
      gate[CMD_DIR] = src_ff[remote_mode ? 6 : 3] == SRC_SERIAL;
      gate[CMD_RUN] = src_ff[remote_mode ? 7 : 4] == SRC_SERIAL;
      gate[CMD_JOG] = src_ff[remote_mode ? 8 : 5] == SRC_SERIAL;
      any_serial = 1'b0;
      for (int i = 0; i < SRC_N; i++) begin
         any_serial = any_serial | (src_ff[i] == SRC_SERIAL);
      end
      nxt_app_ff = cmd_strobe & gate;
      nxt_kp_ff = !any_serial;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         app_ff <= '0;
         kp_ff <= 1'b0;
      end else begin
         app_ff <= nxt_app_ff;
         kp_ff <= nxt_kp_ff;
      end
   end

   // ==========================================================
   // Terminator switch
   logic [1:0] sw;
   logic term_ff, nxt_term_ff, tinv_ff, nxt_tinv_ff;

   cslk_sync2 #(.W(2)) u_sw (
      .clk(clk),
      .rst_b(rst_b),
      .d({terminator_switch_b, terminator_switch_a}),
      .q(sw)
   );

   always_comb begin
      // Invalid mix keeps the last legal state rather than guessing
      nxt_term_ff = (sw == 2'b11) ? 1'b1 : (sw == 2'b00) ? 1'b0 : term_ff;
      nxt_tinv_ff = sw[0] ^ sw[1];
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         term_ff <= 1'b0;
         tinv_ff <= 1'b0;
      end else begin
         term_ff <= nxt_term_ff;
         tinv_ff <= nxt_tinv_ff;
      end
   end

   // ==========================================================
   // Outputs
   assign par_ack = ack_ff;
   assign par_refused = ref_ff;
   assign par_rdata = rdata_ff;
   assign msg_for_us = hit_ff;
   assign baud_div = div_ff;
   assign parity_en = pen_ff;
   assign parity_odd = podd_ff;
   assign two_stop = two_ff;
   assign cmd_apply = app_ff;
   assign keypad_allow = kp_ff;
   assign terminator_on = term_ff;
   assign terminator_invalid = tinv_ff;
   assign link_status = stat_ff;
   assign link_timeout_alarm = alm_ff;
   assign link_timeout_fault = flt_ff;
   assign {err_keep_cmds, err_to_local, err_gen_disable, err_ramp_stop} = errs_ff;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_addr_range;
      addr_ff >= ADDR_MIN && addr_ff <= ADDR_MAX;
   endproperty
   a_addr_range: assert property (p_addr_range) else $error("station address out of range");
   property p_hit_cause;
      hit_ff |-> $past(msg_end) && ($past({8'h00, msg_addr}) == $past(addr_ff));
   endproperty
   a_hit_cause: assert property (p_hit_cause) else $error("message taken for another address");
   property p_idle_fmt;
      line_idle |=> two_ff == ($past(fmt_ff) >= FMT_TWO_STOP) && div_ff == div_of($past(rate_ff));
   endproperty
   a_idle_fmt: assert property (p_idle_fmt) else $error("line setup does not follow settings");
   property p_busy_hold;
      !line_idle |=> $stable(div_ff) && $stable(two_ff) && $stable(pen_ff);
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("line setup changed mid message");
   property p_cfg_lock;
      par_req && par_wr && motor_running && class_of(par_idx) == CL_CFG
         |=> ref_ff && $stable(addr_ff) && $stable(rate_ff) && $stable(fmt_ff) && $stable(act_ff);
   endproperty
   a_cfg_lock: assert property (p_cfg_lock) else $error("setting changed while running");
   property p_ro;
      par_req && par_wr && class_of(par_idx) == CL_RO |=> ack_ff && ref_ff;
   endproperty
   a_ro: assert property (p_ro) else $error("read-only write accepted");
   property p_gate;
      app_ff[CMD_RUN] |-> $past(cmd_strobe[CMD_RUN]) && $past(gate[CMD_RUN]);
   endproperty
   a_gate: assert property (p_gate) else $error("run command from non-serial source");
   property p_keypad;
      kp_ff |-> !$past(any_serial);
   endproperty
   a_keypad: assert property (p_keypad) else $error("keypad allowed while port is source");
   sequence s_both_on;
      (terminator_switch_a && terminator_switch_b) [*4];
   endsequence
   property p_term;
      s_both_on |=> term_ff && !tinv_ff;
   endproperty
   a_term: assert property (p_term) else $error("terminator not on with both switches");
   property p_status;
      stat_ff == ST_WDOG_ERR |-> alm_ff;
   endproperty
   a_status: assert property (p_status) else $error("status error without alarm");
   property p_spoiled;
      msg_end && rx_char_err |=> !hit_ff;
   endproperty
   a_spoiled: assert property (p_spoiled) else $error("spoiled message accepted");
endmodule
`default_nettype wire

// ### core/cslk_pkg.sv
// Constants and types of the serial slave link configuration block.
// Assumes a 40 MHz system clock shared by the framer and the drive logic.
package cslk_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int TENTH_S_NS = 100_000_000;
   localparam int TENTH_CYCLES = TENTH_S_NS / CLK_PERIOD_NS;
   localparam int BAUD_LO = 9600;
   localparam int BAUD_MID = 19200;
   localparam int BAUD_HI = 38400;
   localparam logic [12:0] DIV_LO = 13'(CLK_HZ / BAUD_LO);
   localparam logic [12:0] DIV_MID = 13'(CLK_HZ / BAUD_MID);
   localparam logic [12:0] DIV_HI = 13'(CLK_HZ / BAUD_HI);
   // ==========================================================
   // Setting numbers on the parameter port
   localparam logic [9:0] IDX_ADDR = 10'h134;
   localparam logic [9:0] IDX_RATE = 10'h136;
   localparam logic [9:0] IDX_FMT = 10'h137;
   localparam logic [9:0] IDX_ACT = 10'h139;
   localparam logic [9:0] IDX_TMO = 10'h13a;
   localparam logic [9:0] IDX_STAT = 10'h13c;
   localparam logic [9:0] IDX_SRC0 = 10'h0dc;
   localparam logic [9:0] IDX_SRC8 = 10'h0e4;
   localparam int SRC_N = 9;
   // ==========================================================
   // Limits and values after reset
   localparam logic [15:0] ADDR_MIN = 16'h0001;
   localparam logic [15:0] ADDR_MAX = 16'h00f7;
   localparam logic [15:0] ADDR_RST = 16'h0001;
   localparam logic [15:0] RATE_MAX = 16'h0002;
   localparam logic [15:0] RATE_RST = 16'h0000;
   localparam logic [15:0] FMT_MAX = 16'h0005;
   localparam logic [15:0] FMT_RST = 16'h0001;
   localparam logic [15:0] FMT_TWO_STOP = 16'h0003;
   localparam logic [15:0] ACT_MAX = 16'h0005;
   localparam logic [15:0] ACT_RST = 16'h0000;
   localparam logic [15:0] TMO_MAX = 16'h2706;
   localparam logic [15:0] TMO_RST = 16'h0000;
   localparam logic [15:0] SRC_RST = 16'h0000;
   // ==========================================================
   // Command classes carried over the link
   localparam int CMD_LR = 0;
   localparam int CMD_REF = 1;
   localparam int CMD_DIR = 2;
   localparam int CMD_RUN = 3;
   localparam int CMD_JOG = 4;
   localparam int CMD_N = 5;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      ACT_NONE, ACT_RAMP_STOP, ACT_GEN_DISABLE, ACT_LOCAL, ACT_LOCAL_KEEP, ACT_FAULT
   } cslk_action_t;
   typedef enum logic [1:0] {ST_INACTIVE, ST_ACTIVE, ST_WDOG_ERR} cslk_status_t;
   typedef enum logic [1:0] {CL_NONE, CL_CFG, CL_SRC, CL_RO} cslk_class_t;
endpackage

// ### core/cslk_sync2.sv
// Two flip-flop synchroniser for slow pin levels.
// Assumes inputs are levels that stay put for many clocks.
`timescale 1ns/1ps
`default_nettype none
module cslk_sync2 #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // ==========================================================
   // Stages
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end
   assign q = q_ff;
endmodule
`default_nettype wire

// ### core/cslk_watchdog.sv
// Receive watchdog counting tenths of a second since the last good message.
// Assumes msg_good is a one-cycle pulse per accepted message.
`timescale 1ns/1ps
`default_nettype none
module cslk_watchdog #(
   parameter int TENTH_CYCLES = cslk_pkg::TENTH_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Events and setting
   input wire logic msg_good,
   input wire logic [15:0] timeout,
   output logic expired
);
   import cslk_pkg::*;
   logic armed_ff, nxt_armed_ff, exp_ff, nxt_exp_ff;
   logic [31:0] pre_ff, nxt_pre_ff;
   logic [15:0] tenth_ff, nxt_tenth_ff;

   if (TENTH_CYCLES < 1) begin : g_chk
      $error("TENTH_CYCLES must be at least one");
   end

   // ==========================================================
   // Counting
   always_comb begin
      nxt_armed_ff = armed_ff | msg_good;
      nxt_pre_ff = pre_ff;
      nxt_tenth_ff = tenth_ff;
      if (msg_good || !armed_ff) begin
         nxt_pre_ff = '0;
         nxt_tenth_ff = '0;
      end else if (pre_ff == 32'(TENTH_CYCLES - 1)) begin
         nxt_pre_ff = '0;
         // Saturate so a long silence cannot wrap back to good
         if (tenth_ff != 16'hffff) begin
            nxt_tenth_ff = tenth_ff + 16'h0001;
         end
      end else begin
         nxt_pre_ff = pre_ff + 32'h1;
      end
      nxt_exp_ff = nxt_armed_ff && !msg_good && (timeout != 16'h0000)
                   && (nxt_tenth_ff >= timeout);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         armed_ff <= 1'b0;
         pre_ff <= '0;
         tenth_ff <= '0;
         exp_ff <= 1'b0;
      end else begin
         armed_ff <= nxt_armed_ff;
         pre_ff <= nxt_pre_ff;
         tenth_ff <= nxt_tenth_ff;
         exp_ff <= nxt_exp_ff;
      end
   end
   assign expired = exp_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_wd_zero_off;
      (timeout == 16'h0000) |=> !exp_ff;
   endproperty
   a_wd_zero_off: assert property (p_wd_zero_off) else $error("watchdog fired while disabled");
   property p_wd_unarmed;
      !armed_ff |-> !exp_ff;
   endproperty
   a_wd_unarmed: assert property (p_wd_unarmed) else $error("watchdog fired before first message");
endmodule
`default_nettype wire

// ### tb/cslk_master_model.sv
// Network master model driving the framer side of the link block.
// Assumes the bench calls send; one message at a time.
`timescale 1ns/1ps
`default_nettype none
module cslk_master_model (
   // Clock
   input wire logic clk,
   // Framer events
   output logic line_idle,
   output logic rx_char_err,
   output logic msg_end,
   output logic msg_crc_ok,
   output logic [7:0] msg_addr
);
   // ==========================================================
   // Message sequencer
   initial begin
      line_idle = 1'b1;
      rx_char_err = 1'b0;
      msg_end = 1'b0;
      msg_crc_ok = 1'b0;
      msg_addr = 8'h00;
   end
   // Same rate and format as the device by construction
   // Callers give each station its own address
   task automatic send(input logic [7:0] a, input logic crc, input logic bad, input int gap);
      @(posedge clk);
      line_idle <= 1'b0;
      rx_char_err <= bad;
      repeat (gap + 1) @(posedge clk);
      msg_end <= 1'b1;
      msg_crc_ok <= crc;
      msg_addr <= a;
      @(posedge clk);
      // Released fields show junk, not the old value
      msg_end <= 1'b0;
      rx_char_err <= 1'b0;
      msg_crc_ok <= ~crc;
      msg_addr <= ~a;
      line_idle <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ### tb/tb_cslk_top.sv
// Self-checking bench of the link configuration block.
// Assumes the watchdog tenth shortened to 4 clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_cslk_top;
   import cslk_pkg::*;
   // ==========================================================
   // Signals
   logic clk = 1'b0, rst_b = 1'b0, par_req = 1'b0, par_wr = 1'b0, motor_running = 1'b0, sa = 1'b0, sb = 1'b0;
   logic [9:0] par_idx = 10'h000;
   logic [15:0] par_wdata = 16'h0000;
   logic [4:0] cmd_strobe = 5'h00;
   logic par_ack, par_refused, msg_for_us, parity_en, parity_odd, two_stop, keypad_allow;
   logic li, ce, me, mc, t_on, t_inv, alarm, ramp, flt, gd, tl, kc, rm = 1'b0, fr = 1'b0, ip = 1'b1;
   logic [7:0] ma;
   logic [15:0] par_rdata;
   logic [12:0] baud_div;
   logic [4:0] cmd_apply;
   logic [1:0] link_status;
   int mismatches = 0, comparisons = 0, n;
   always #12.5 clk = ~clk;
   cslk_master_model u_m (.clk(clk), .line_idle(li), .rx_char_err(ce), .msg_end(me), .msg_crc_ok(mc),
      .msg_addr(ma));
   cslk_top #(.TENTH_CYCLES(4)) u_dut (.clk(clk), .rst_b(rst_b), .par_req(par_req), .par_wr(par_wr),
      .par_idx(par_idx), .par_wdata(par_wdata), .par_ack(par_ack), .par_refused(par_refused),
      .par_rdata(par_rdata), .motor_running(motor_running), .remote_mode(rm), .iface_present(ip),
      .fault_reset(fr), .line_idle(li), .rx_char_err(ce), .msg_end(me), .msg_crc_ok(mc), .msg_addr(ma),
      .msg_for_us(msg_for_us), .baud_div(baud_div), .parity_en(parity_en), .parity_odd(parity_odd),
      .two_stop(two_stop), .cmd_strobe(cmd_strobe), .cmd_apply(cmd_apply), .keypad_allow(keypad_allow),
      .terminator_switch_a(sa), .terminator_switch_b(sb), .terminator_on(t_on), .terminator_invalid(t_inv),
      .link_status(link_status), .link_timeout_alarm(alarm), .link_timeout_fault(flt), .err_ramp_stop(ramp),
      .err_gen_disable(gd), .err_to_local(tl), .err_keep_cmds(kc));
   // ==========================================================
   // Helpers
   task automatic finish_test;
      if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic acc(input logic w, input logic [9:0] i, input logic [15:0] d, input logic rf,
      input logic [15:0] rd);
      @(posedge clk);
      par_req <= 1'b1;
      par_wr <= w;
      par_idx <= i;
      par_wdata <= d;
      @(posedge clk);
      par_req <= 1'b0;
      #1;
      chk("ack", 16'({par_ack, par_refused}), 16'({1'b1, rf}));
      if (!w) chk("rdata", par_rdata, rd);
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs;
      acc(1'b0, IDX_ADDR, 16'h0000, 1'b0, ADDR_RST);
      acc(1'b0, IDX_FMT, 16'h0000, 1'b0, FMT_RST);
      chk("div", 16'(baud_div), 16'(DIV_LO));
      acc(1'b1, IDX_ADDR, 16'h0000, 1'b1, 16'h0000);
      acc(1'b1, IDX_ADDR, 16'h00f8, 1'b1, 16'h0000);
      acc(1'b1, IDX_ADDR, 16'h00f7, 1'b0, 16'h0000);
      acc(1'b0, IDX_ADDR, 16'h0000, 1'b0, 16'h00f7);
      acc(1'b1, IDX_STAT, 16'h0000, 1'b1, 16'h0000);
      acc(1'b0, IDX_STAT, 16'h0000, 1'b0, 16'h0001);
      acc(1'b1, IDX_RATE, 16'h0003, 1'b1, 16'h0000);
      motor_running <= 1'b1;
      acc(1'b1, IDX_ACT, 16'h0001, 1'b1, 16'h0000);
      motor_running <= 1'b0;
      acc(1'b1, IDX_ADDR, 16'h0005, 1'b0, 16'h0000);
   endtask
   task automatic t_line;
      logic [12:0] dv[3];
      dv = '{DIV_LO, DIV_MID, DIV_HI};
      for (int r = 0; r < 3; r++) begin
         acc(1'b1, IDX_RATE, 16'(r), 1'b0, 16'h0000);
         tick(2);
         chk("div", 16'(baud_div), 16'(dv[r]));
      end
      for (int f = 0; f < 6; f++) begin
         acc(1'b1, IDX_FMT, 16'(f), 1'b0, 16'h0000);
         tick(2);
         chk("fmt", 16'({parity_en, parity_odd, two_stop}), 16'({f % 3 != 0, f % 3 == 2, f > 2}));
      end
      // Busy line must keep the old divider
      fork
         u_m.send(8'h09, 1'b1, 1'b0, 8);
         begin
            acc(1'b1, IDX_RATE, 16'h0000, 1'b0, 16'h0000);
            tick(2);
            chk("div busy", 16'(baud_div), 16'(DIV_HI));
         end
      join
      tick(2);
      chk("div idle", 16'(baud_div), 16'(DIV_LO));
   endtask
   task automatic msg(input logic [7:0] a, input logic crc, input logic bad, input logic e);
      u_m.send(a, crc, bad, 0);
      #1;
      chk("for_us", 16'(msg_for_us), 16'(e));
   endtask
   task automatic t_wdog;
      msg(8'h05, 1'b1, 1'b0, 1'b1);
      msg(8'h06, 1'b1, 1'b0, 1'b0);
      msg(8'h05, 1'b1, 1'b1, 1'b0);
      msg(8'h05, 1'b0, 1'b0, 1'b0);
      acc(1'b1, IDX_ACT, 16'h0001, 1'b0, 16'h0000);
      acc(1'b1, IDX_TMO, 16'h0002, 1'b0, 16'h0000);
      msg(8'h05, 1'b1, 1'b0, 1'b1);
      tick(3);
      chk("status", 16'(link_status), 16'h0001);
      for (n = 0; n < 40 && link_status !== 2'h2; n++) tick(1);
      if (n == 40) begin
         mismatches++;
         finish_test;
      end
      chk("alarm", 16'({alarm, ramp}), 16'h0003);
      for (int a = 2; a < 6; a++) begin
         acc(1'b1, IDX_ACT, 16'(a), 1'b0, 16'h0000);
         tick(1);
         chk("act", 16'({flt, kc, tl, gd, ramp}), 16'(1 << (a - 1)));
      end
      msg(8'h05, 1'b1, 1'b0, 1'b1);
      tick(3);
      chk("alarm clr", 16'(alarm), 16'h0000);
      chk("fault", 16'(flt), 16'h0001);
      fr <= 1'b1;
      tick(1);
      fr <= 1'b0;
      chk("fault clr", 16'(flt), 16'h0000);
      acc(1'b1, IDX_TMO, 16'h0000, 1'b0, 16'h0000);
      tick(30);
      chk("status off", 16'(link_status), 16'h0001);
   endtask
   task automatic t_cmd(input logic [4:0] e);
      @(posedge clk);
      cmd_strobe <= 5'h08;
      @(posedge clk);
      cmd_strobe <= 5'h00;
      #1;
      chk("apply", 16'(cmd_apply), 16'(e));
   endtask
   task automatic t_term(input logic a, input logic b, input logic [1:0] e);
      @(posedge clk);
      sa <= a;
      sb <= b;
      tick(4);
      chk("term", 16'({t_on, t_inv}), 16'(e));
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      t_regs;
      t_line;
      t_wdog;
      t_cmd(5'h00);
      chk("keypad", 16'(keypad_allow), 16'h0001);
      acc(1'b1, IDX_SRC0 + 10'h004, 16'h0002, 1'b0, 16'h0000);
      t_cmd(5'h08);
      chk("keypad", 16'(keypad_allow), 16'h0000);
      rm <= 1'b1;
      t_cmd(5'h00);
      t_term(1'b1, 1'b1, 2'h2);
      t_term(1'b0, 1'b1, 2'h3);
      t_term(1'b0, 1'b0, 2'h0);
      rst_b <= 1'b0;
      tick(2);
      rst_b <= 1'b1;
      acc(1'b0, IDX_ADDR, 16'h0000, 1'b0, ADDR_RST);
      acc(1'b1, IDX_TMO, 16'h0002, 1'b0, 16'h0000);
      tick(20);
      chk("unarmed", 16'(link_status), 16'h0001);
      ip <= 1'b0;
      tick(1);
      chk("inactive", 16'(link_status), 16'h0000);
      finish_test;
   end
endmodule
`default_nettype wire
